// ==== hhc_engine.sv ====
// host-to-host compression command interpreter, device side
// assumes host glue presents word-wide command and status registers
`timescale 1ns/1ps
`default_nettype none
`include "hhc_cfg.svh"
module hhc_engine (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata_ff,
  output logic status_ready_ff,
  output logic active_ff,
  output hhc_pkg::hhc_setup_t setup_ff,
  output logic [15:0] sample_ff,
  output logic sample_vld_ff,
  output logic frame_accept_ff,
  input wire logic can_accept
);

  // ***********************************************************
  // decode helpers
  // ***********************************************************
  function automatic logic is_comp(input logic [15:0] w);
    is_comp = (w[`HHC_OPC_HI:`HHC_OPC_LO] == `HHC_OPC_COMP) && (w[6:3] == 4'h0);
  endfunction : is_comp

  function automatic logic fmt_ok(input logic [2:0] f);
    fmt_ok = (f == hhc_pkg::HHC_FMT_SPEECH) || f[2]; // 001..011 reserved
  endfunction : fmt_ok

  logic cmd_wr;
  logic stat_rd;
  logic [15:0] status_word_ff;
  logic started_ff;
  logic [7:0] word_cnt_ff;
  hhc_pkg::hhc_state_t state_ff;
  assign cmd_wr = wr_stb && (addr == `HHC_ADDR_CMD);
  assign stat_rd = rd_stb && (addr == `HHC_ADDR_STAT);

  // ***********************************************************
  // command sequencing
  // ***********************************************************
  // state: idle, active (commands), xfer (frame words)
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= hhc_pkg::HHC_IDLE;
      word_cnt_ff <= 8'h00;
    end
    else
    begin
      case (state_ff)
        hhc_pkg::HHC_IDLE:
        begin
          if (cmd_wr && is_comp(wdata) && wdata[`HHC_PEND_BIT] && can_accept)
          begin
            state_ff <= hhc_pkg::HHC_XFER;
            word_cnt_ff <= 8'h00;
          end
          else if (cmd_wr && is_comp(wdata))
            state_ff <= hhc_pkg::HHC_ACTIVE;
        end
        hhc_pkg::HHC_ACTIVE:
        begin
          if (cmd_wr && ((wdata == `HHC_CMD_IDLE) || (wdata == `HHC_CMD_REC_STOP)))
            state_ff <= hhc_pkg::HHC_IDLE;
          else if (cmd_wr && is_comp(wdata) && can_accept)
          begin
            state_ff <= hhc_pkg::HHC_XFER;
            word_cnt_ff <= 8'h00;
          end
        end
        hhc_pkg::HHC_XFER:
        begin
          if (cmd_wr)
          begin
            word_cnt_ff <= word_cnt_ff + 8'h01;
            if (word_cnt_ff == `HHC_FRAME_WORDS - 8'h01)
              state_ff <= hhc_pkg::HHC_ACTIVE;
          end
        end
        default: state_ff <= hhc_pkg::HHC_IDLE;
      endcase
    end
  end

  // first-command marker, cleared when compression ends
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      started_ff <= 1'b0;
    else
      started_ff <= (state_ff != hhc_pkg::HHC_IDLE);
  end

  // mode capture from every compression command
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      setup_ff <= '0;
    else if (cmd_wr && is_comp(wdata) && (state_ff != hhc_pkg::HHC_XFER))
    begin
      setup_ff.compression_format <= wdata[`HHC_FMT_HI:`HHC_FMT_LO];
      setup_ff.transfer_mode <= wdata[`HHC_TM_HI:`HHC_TM_LO];
      setup_ff.fmt_valid <= fmt_ok(wdata[`HHC_FMT_HI:`HHC_FMT_LO]);
    end
  end

  // ***********************************************************
  // status word and status-ready
  // ***********************************************************
  // status echo; poll answers are side-effect free
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      status_word_ff <= 16'h0000;
    else if (cmd_wr)
    begin
      if (state_ff == hhc_pkg::HHC_XFER)
        status_word_ff <= wdata;
      else if (wdata == `HHC_CMD_POLL)
        status_word_ff <= can_accept ? `HHC_POLL_READY : `HHC_POLL_BUSY;
      else if (is_comp(wdata))
      begin
        status_word_ff <= {wdata[15:1], 1'b0};
        if (state_ff == hhc_pkg::HHC_IDLE)
          status_word_ff[0] <= wdata[`HHC_PEND_BIT] && can_accept;
        else
          status_word_ff[0] <= can_accept;
      end
      else
        status_word_ff <= wdata; // record-path commands echoed
    end
  end

  // set wins over the read clear
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      status_ready_ff <= 1'b0;
    else if (cmd_wr)
      status_ready_ff <= 1'b1;
    else if (stat_rd)
      status_ready_ff <= 1'b0;
  end

  // read data one cycle after the strobe
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rdata_ff <= 16'h0000;
    else if (stat_rd)
      rdata_ff <= status_word_ff;
    else if (rd_stb)
      rdata_ff <= {15'h0000, status_ready_ff};
    else
      rdata_ff <= 16'h0000;
  end

  // ***********************************************************
  // sample stream to the compressor
  // ***********************************************************
  // linear words go to the engine, never to a codec
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sample_ff <= 16'h0000;
      sample_vld_ff <= 1'b0;
      frame_accept_ff <= 1'b0;
      active_ff <= 1'b0;
    end
    else
    begin
      sample_vld_ff <= cmd_wr && (state_ff == hhc_pkg::HHC_XFER);
      if (cmd_wr && (state_ff == hhc_pkg::HHC_XFER))
        sample_ff <= wdata;
      frame_accept_ff <= (state_ff != hhc_pkg::HHC_XFER) && (state_ff_nxt_xfer());
      active_ff <= started_ff;
    end
  end

  function automatic logic state_ff_nxt_xfer();
    state_ff_nxt_xfer = cmd_wr && is_comp(wdata) && can_accept &&
      ((state_ff == hhc_pkg::HHC_ACTIVE) || wdata[`HHC_PEND_BIT]);
  endfunction : state_ff_nxt_xfer

  // ***********************************************************
  // checks
  // ***********************************************************
  ready_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr |=> status_ready_ff) else $error("status ready not set after write");
  ready_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    status_ready_ff && !stat_rd && !cmd_wr |=> status_ready_ff)
    else $error("status ready dropped without read");
  echo_word_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_XFER |=> status_word_ff == $past(wdata))
    else $error("word echo wrong");
  poll_ans_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && wdata == `HHC_CMD_POLL && state_ff == hhc_pkg::HHC_ACTIVE
    |=> status_word_ff == ($past(can_accept) ? 16'h0000 : 16'h0001))
    else $error("poll answer wrong");
  poll_free_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && wdata == `HHC_CMD_POLL && state_ff == hhc_pkg::HHC_ACTIVE
    |=> state_ff == hhc_pkg::HHC_ACTIVE) else $error("poll started transfer");
  first_ready_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_IDLE && is_comp(wdata) && wdata[0] && can_accept
    |=> status_word_ff[0] && state_ff == hhc_pkg::HHC_XFER)
    else $error("first ready not set");
  stop_ends_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_ACTIVE && wdata == `HHC_CMD_IDLE
    |=> state_ff == hhc_pkg::HHC_IDLE ##2 !active_ff[*2]) else $error("stop ignored");
  comp_echo_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && is_comp(wdata) && state_ff != hhc_pkg::HHC_XFER
    |=> status_word_ff[15:1] == $past(wdata[15:1])) else $error("status echo wrong");
  later_ready_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && is_comp(wdata) && state_ff == hhc_pkg::HHC_ACTIVE && !wdata[0] && can_accept
    |=> status_word_ff[0]) else $error("pending flag not ignored");

  // ***********************************************************
  // checks: register port and status flag
  // ***********************************************************
  // a status read clears the flag when no write races it
  stat_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    stat_rd && !cmd_wr |=> !status_ready_ff)
    else $error("status ready not cleared by read");
  // status read returns the stored word one cycle later
  rd_data_a: assert property (@(posedge clock) disable iff (!reset_n)
    stat_rd |=> rdata_ff == $past(status_word_ff))
    else $error("status read data wrong");
  // read data only in the cycle after a strobe
  rd_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
    !rd_stb |=> rdata_ff == 16'h0000)
    else $error("read data not idle");
  // command-address read shows the flag without clearing it
  hw_read_a: assert property (@(posedge clock) disable iff (!reset_n)
    rd_stb && addr == `HHC_ADDR_CMD |=> rdata_ff == {15'h0, $past(status_ready_ff)})
    else $error("flag read wrong");
  // flag survives a read of the command address
  rd_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
    rd_stb && addr == `HHC_ADDR_CMD && status_ready_ff |=> status_ready_ff)
    else $error("flag cleared by wrong read");
  // flag never rises without a write
  no_ready_a: assert property (@(posedge clock) disable iff (!reset_n)
    !status_ready_ff && !cmd_wr |=> !status_ready_ff)
    else $error("flag set without write");
  // status word only moves on a command write
  status_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !cmd_wr |=> $stable(status_word_ff))
    else $error("status word moved");
  // reserved command bits come back as zeros
  comp_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && is_comp(wdata) && state_ff != hhc_pkg::HHC_XFER |=> status_word_ff[6:3] == 4'h0)
    else $error("status zero field wrong");
  // record-path commands are echoed while active
  rec_echo_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_ACTIVE && !is_comp(wdata) && wdata != `HHC_CMD_POLL
    |=> status_word_ff == $past(wdata)) else $error("record command not echoed");

  // ***********************************************************
  // checks: frame pacing and sample stream
  // ***********************************************************
  // each frame word reaches the compressor once
  sample_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_XFER |=> sample_vld_ff && sample_ff == $past(wdata))
    else $error("sample not passed on");
  // no sample outside a frame transfer
  sample_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !(cmd_wr && state_ff == hhc_pkg::HHC_XFER) |=> !sample_vld_ff)
    else $error("stray sample");
  // a valid sample always follows a frame-state write
  vld_xfer_a: assert property (@(posedge clock) disable iff (!reset_n)
    sample_vld_ff |-> $past(state_ff == hhc_pkg::HHC_XFER))
    else $error("sample from wrong state");
  // the last frame word hands control back to commands
  frame_count_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_XFER && word_cnt_ff == `HHC_FRAME_WORDS - 8'h01
    |=> state_ff == hhc_pkg::HHC_ACTIVE) else $error("frame end missed");
  // earlier words step the counter and stay in the frame
  count_step_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_XFER && word_cnt_ff != `HHC_FRAME_WORDS - 8'h01
    |=> state_ff == hhc_pkg::HHC_XFER && word_cnt_ff == $past(word_cnt_ff) + 8'h01)
    else $error("word count step wrong");
  // counter never passes the frame length
  count_bound_a: assert property (@(posedge clock) disable iff (!reset_n)
    state_ff == hhc_pkg::HHC_XFER |-> word_cnt_ff < `HHC_FRAME_WORDS)
    else $error("word count overrun");
  // frame state waits for the host between words
  xfer_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    state_ff == hhc_pkg::HHC_XFER && !cmd_wr
    |=> state_ff == hhc_pkg::HHC_XFER && $stable(word_cnt_ff)) else $error("frame moved alone");
  // entering a frame is always marked by a grant
  grant_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
    state_ff != hhc_pkg::HHC_XFER ##1 state_ff == hhc_pkg::HHC_XFER |-> frame_accept_ff)
    else $error("frame grant missing");
  // a grant only at the start of a frame
  grant_only_a: assert property (@(posedge clock) disable iff (!reset_n)
    frame_accept_ff |-> state_ff == hhc_pkg::HHC_XFER && word_cnt_ff == 8'h00)
    else $error("stray frame grant");
  // busy compressor: later command gets ready low
  busy_later_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && is_comp(wdata) && state_ff == hhc_pkg::HHC_ACTIVE && !can_accept
    |=> state_ff == hhc_pkg::HHC_ACTIVE && !status_word_ff[0]) else $error("busy ready set");
  // busy compressor never grants a frame
  accept_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && is_comp(wdata) && state_ff != hhc_pkg::HHC_XFER && !can_accept
    |=> state_ff != hhc_pkg::HHC_XFER && !frame_accept_ff) else $error("busy grant");
  // first command without pending flag owes no frame
  first_wait_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_IDLE && is_comp(wdata) && !wdata[`HHC_PEND_BIT]
    |=> state_ff == hhc_pkg::HHC_ACTIVE && !status_word_ff[0]) else $error("first wait wrong");
  // other commands do not start compression
  idle_ignore_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_IDLE && !is_comp(wdata)
    |=> state_ff == hhc_pkg::HHC_IDLE) else $error("idle left on wrong command");
  // a poll while idle leaves the engine idle
  poll_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_IDLE && wdata == `HHC_CMD_POLL
    |=> state_ff == hhc_pkg::HHC_IDLE) else $error("poll left idle");
  // record stop also ends compression
  stop_rec_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_ACTIVE && wdata == `HHC_CMD_REC_STOP
    |=> state_ff == hhc_pkg::HHC_IDLE) else $error("record stop ignored");
  // other record commands keep compression running
  rec_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_ACTIVE && !is_comp(wdata) &&
    wdata != `HHC_CMD_IDLE && wdata != `HHC_CMD_REC_STOP
    |=> state_ff == hhc_pkg::HHC_ACTIVE) else $error("record command stopped run");
  // setup only changes on a compression command
  setup_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    !(cmd_wr && is_comp(wdata) && state_ff != hhc_pkg::HHC_XFER) |=> $stable(setup_ff))
    else $error("setup moved");
  // reserved formats are flagged invalid
  fmt_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && is_comp(wdata) && state_ff != hhc_pkg::HHC_XFER &&
    wdata[`HHC_FMT_HI:`HHC_FMT_LO] inside {3'h1, 3'h2, 3'h3}
    |=> !setup_ff.fmt_valid) else $error("reserved format accepted");
  // activity shows two cycles after the state turns
  active_rise_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_wr && state_ff == hhc_pkg::HHC_IDLE && is_comp(wdata) |=> ##2 active_ff)
    else $error("active not raised");

endmodule : hhc_engine
`default_nettype wire

// ==== hhc_cfg.svh ====
// constants for the host-to-host compression command interpreter
// assumes: 16-bit command/status words, register port driven by host glue
`ifndef HHC_CFG_SVH
`define HHC_CFG_SVH
`define HHC_ADDR_CMD 1'h0
`define HHC_ADDR_STAT 1'h1
`define HHC_OPC_COMP 6'h3D
`define HHC_OPC_HI 15
`define HHC_OPC_LO 10
`define HHC_FMT_HI 9
`define HHC_FMT_LO 7
`define HHC_TM_HI 2
`define HHC_TM_LO 1
`define HHC_PEND_BIT 0
`define HHC_CMD_POLL 16'h5119
`define HHC_CMD_IDLE 16'h0000
`define HHC_CMD_REC_STOP 16'h5000
`define HHC_POLL_READY 16'h0000
`define HHC_POLL_BUSY 16'h0001
`define HHC_FRAME_WORDS 8'hF0
`define HHC_PROC_CYCLES 8'h04
`endif

// ==== hhc_pkg.sv ====
// types for the host-to-host compression command interpreter
// assumes hhc_cfg.svh supplies the numbers
package hhc_pkg;
  typedef enum logic [2:0] {
    HHC_FMT_SPEECH = 3'h0,
    HHC_FMT_PCM = 3'h4,
    HHC_FMT_LIN16 = 3'h5,
    HHC_FMT_S8 = 3'h6,
    HHC_FMT_U8 = 3'h7
  } hhc_fmt_t;
  typedef enum logic [1:0] {HHC_IDLE, HHC_ACTIVE, HHC_XFER} hhc_state_t;
  typedef struct packed {
    logic [2:0] compression_format;
    logic [1:0] transfer_mode;
    logic fmt_valid;
  } hhc_setup_t;
endpackage : hhc_pkg

// ==== hhc_host_model.sv ====
// host processor model driving the command and status register port
// assumes one clock; strobes change by non-blocking assignment after edges
`timescale 1ns/1ps
`default_nettype none
`include "hhc_cfg.svh"
module hhc_host_model (
  input wire logic clock,
  input wire logic status_ready_ff,
  input wire logic [15:0] rdata_ff,
  output var logic addr,
  output var logic [15:0] wdata,
  output var logic wr_stb,
  output var logic rd_stb
);
  // ****************
  // bus cycles
  // ****************
  // idle bus: no strobes, address and data zero
  initial
  begin
    addr = 1'h0;
    wdata = 16'h0000;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
  end
  // one write, whole 16-bit word
  task automatic wr(input logic [15:0] d);
    @(posedge clock);
    addr <= `HHC_ADDR_CMD;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clock);
    wr_stb <= 1'h0;
  endtask : wr
  // write, wait for pending status, read it; a hang is reported via ok
  task automatic handshake(input logic [15:0] d, output logic [15:0] s, output logic ok);
    int n;
    wr(d);
    n = 0;
    #1;
    while (status_ready_ff !== 1'h1 && n < 64)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    ok = (n < 64);
    @(posedge clock);
    addr <= `HHC_ADDR_STAT;
    rd_stb <= 1'h1;
    @(posedge clock);
    rd_stb <= 1'h0;
    #1;
    s = rdata_ff; // read data stand one cycle only
  endtask : handshake
endmodule : hhc_host_model
`default_nettype wire

// ==== test_host_to_host_compression_protocol.sv ====
// self-checking bench for the compression command interpreter
// assumes hhc_host_model drives the register port, bench drives can_accept
`timescale 1ns/1ps
`default_nettype none
`include "hhc_cfg.svh"
module test_host_to_host_compression_protocol;
  logic clock;
  logic reset_n;
  logic can_accept;
  logic addr;
  logic [15:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] rdata_ff;
  logic status_ready_ff;
  logic active_ff;
  hhc_pkg::hhc_setup_t setup_ff;
  logic [15:0] sample_ff;
  logic sample_vld_ff;
  logic frame_accept_ff;
  int failures;
  int checked;
  int vld_seen = 0;
  int grant_seen = 0;
  // count sample and grant pulses, they stand one cycle only
  always @(posedge clock)
  begin
    if (sample_vld_ff === 1'b1)
      vld_seen++;
    if (frame_accept_ff === 1'b1)
      grant_seen++;
  end
  // ****************
  // design and host
  // ****************
  hhc_engine dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff), .status_ready_ff(status_ready_ff),
    .active_ff(active_ff), .setup_ff(setup_ff), .sample_ff(sample_ff),
    .sample_vld_ff(sample_vld_ff), .frame_accept_ff(frame_accept_ff), .can_accept(can_accept));
  hhc_host_model host (.clock(clock), .status_ready_ff(status_ready_ff), .rdata_ff(rdata_ff),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // compressor readiness changes only at an edge
  task automatic acc(input logic v);
    @(posedge clock);
    can_accept <= v;
  endtask : acc
  // one exchange; pending status must be gone after the read
  task automatic xchg(input logic [15:0] c, input logic [15:0] exp);
    logic [15:0] s;
    logic ok;
    host.handshake(c, s, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(s, exp);
    chk({15'h0, status_ready_ff}, 16'h0000);
  endtask : xchg
  // 240 words, each echoed and handed on to the compressor
  task automatic frame(input logic [15:0] base);
    for (int i = 0; i < 240; i++)
    begin
      xchg(base + 16'(i), base + 16'(i));
      chk(sample_ff, base + 16'(i));
    end
  endtask : frame
  // stop code ends the run; its status is not defined, so only activity is judged
  task automatic stop(input logic [15:0] c);
    logic [15:0] s;
    logic ok;
    host.handshake(c, s, ok);
    repeat (4) @(posedge clock);
    #1;
    chk({15'h0, active_ff}, 16'h0000);
  endtask : stop
  // ****************
  // scenarios
  // ****************
  task automatic t_frames;
    acc(1'h1);
    xchg(16'hF401, 16'hF401);
    frame(16'h1000);
    chk({15'h0, active_ff}, 16'h0001);
    xchg(16'hF680, 16'hF681);
    frame(16'hA5F0);
    chk(16'(vld_seen), 16'h01E0);
    chk(16'(grant_seen), 16'h0002);
    $display("frames done");
  endtask : t_frames
  // every format code with ready low, so no frame is owed
  task automatic t_formats;
    logic [15:0] c;
    acc(1'h0);
    for (int f = 0; f < 8; f++)
    begin
      c = {6'h3D, 3'(f), 4'h0, 2'(f), 1'h1};
      xchg(c, c & 16'hFFFE);
      chk({13'h0, setup_ff.compression_format}, 16'(f));
      chk({14'h0, setup_ff.transfer_mode}, 16'(f % 4));
      chk({15'h0, setup_ff.fmt_valid}, (f == 0 || f > 3) ? 16'h1 : 16'h0);
    end
    $display("formats done");
  endtask : t_formats
  task automatic t_poll;
    acc(1'h1);
    xchg(16'h5119, 16'h0000);
    acc(1'h0);
    xchg(16'h5119, 16'h0001);
    acc(1'h1);
    xchg(16'h5119, 16'h0000);
    acc(1'h0);
    xchg(16'hF702, 16'hF702);
    $display("poll done");
  endtask : t_poll
  task automatic t_stop;
    stop(`HHC_CMD_REC_STOP);
    acc(1'h1);
    xchg(16'hF400, 16'hF400);
    chk({15'h0, active_ff}, 16'h0001);
    xchg(16'h5100, 16'h5100);
    chk({15'h0, active_ff}, 16'h0001);
    stop(16'h0000);
    $display("stop done");
  endtask : t_stop
  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // ****************
  // clock, sequence, watchdog
  // ****************
  initial
  begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    failures = 0;
    checked = 0;
    reset_n = 1'h0;
    can_accept = 1'h0;
    repeat (8) @(posedge clock);
    reset_n <= 1'h1;
    t_frames;
    t_formats;
    t_poll;
    t_stop;
    summarize;
  end
  // about ten times the expected run length
  initial
  begin
    #100000;
    failures++;
    summarize;
  end
endmodule : test_host_to_host_compression_protocol
`default_nettype wire
